/* File: common/sadc_pkg.sv */
// sadc_pkg: constants and carrier types for the sar converter control block.
// assumes: one 100 MHz reference clock, 8-bit register port, async high reset.
`default_nettype none

package sadc_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] SADC_OFF_RESULT = 8'h1E;    // conversion_result
    localparam logic [7:0] SADC_OFF_CTL0   = 8'h1F;    // converter_control_0
    localparam logic [7:0] SADC_OFF_PINCFG = 8'h9F;    // converter_pin_config
    localparam logic [7:0] SADC_OFF_FLAG   = 8'h0C;    // conv_irq_flag holder

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int SADC_CLKSEL_LSB = 6;                // conv_clock_select 7:6
    localparam int SADC_CHAN_LSB   = 3;                // channel_select 5:3
    localparam int SADC_GO_BIT     = 2;                // start/done status
    localparam int SADC_POWER_BIT  = 0;                // converter_power_on
    localparam int SADC_FLAG_BIT   = 0;                // conv_irq_flag

    // ------------------------------------------------------------------
    // conversion clock select codes and bit period terminal counts
    // ------------------------------------------------------------------
    localparam logic [1:0] SADC_CLK_DIV2  = 2'h0;      // 2 osc periods
    localparam logic [1:0] SADC_CLK_DIV8  = 2'h1;      // 8 osc periods
    localparam logic [1:0] SADC_CLK_DIV32 = 2'h2;      // 32 osc periods
    localparam logic [1:0] SADC_CLK_RC    = 2'h3;      // internal rc clock
    localparam logic [4:0] SADC_TC_DIV2   = 5'h01;     // count 0..1
    localparam logic [4:0] SADC_TC_DIV8   = 5'h07;     // count 0..7
    localparam logic [4:0] SADC_TC_DIV32  = 5'h1F;     // count 0..31

    // ------------------------------------------------------------------
    // conversion sequence
    // ------------------------------------------------------------------
    localparam logic [3:0] SADC_LAST_STEP = 4'h8;      // 9 bit periods: 0..8
    localparam logic [7:0] SADC_MSB_MASK  = 8'h80;     // first trial bit

    // ------------------------------------------------------------------
    // pin use: bit order p0,p1,p2,p3,p5 (bit 4 is p5); 1 = analog
    // ------------------------------------------------------------------
    localparam logic [4:0] SADC_PINS_ALL   = 5'h1F;    // 000, 010
    localparam logic [4:0] SADC_PINS_REF3  = 5'h17;    // 001, 011: p3 is ref
    localparam logic [4:0] SADC_PINS_013   = 5'h0B;    // 100
    localparam logic [4:0] SADC_PINS_01    = 5'h03;    // 101: p3 is ref
    localparam logic [4:0] SADC_PINS_NONE  = 5'h00;    // 11x

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        SADC_IDLE = 1'b0,                              // waiting for start
        SADC_CONV = 1'b1                               // bit periods running
    } sadc_state_t;

    typedef struct packed {
        logic [1:0]  clk_sel;                          // conv_clock_select
        logic [2:0]  chan;                             // channel_select
        logic        go;                               // start/done status
        logic        power;                            // converter_power_on
        logic [2:0]  pcfg;                             // port_pin_config
        logic [4:0]  pin_mask;                         // decoded analog pins
        logic        vref_ext;                         // p3 used as reference
        logic        irq_flag;                         // conv_irq_flag
        sadc_state_t state;                            // sequencer state
        logic [1:0]  conv_sel;                         // clock held per run
        logic [3:0]  step;                             // bit period index
        logic [7:0]  trial;                            // sar trial code
        logic [7:0]  mask;                             // bit under test
        logic [7:0]  rdata;                            // read data
    } sadc_regs_t;

    typedef struct packed {
        logic [4:0]  div;                              // osc cycle count
        logic        rc_prev;                          // last rc level
    } sadc_tmr_t;

    localparam sadc_regs_t SADC_REGS_RST = '{pin_mask: SADC_PINS_ALL, state: SADC_IDLE, default: '0};
    localparam sadc_tmr_t  SADC_TMR_RST  = '{default: '0};

endpackage : sadc_pkg

`default_nettype wire

/* File: rtl/sadc_bit_timer.sv */
// sadc_bit_timer: makes one pulse per conversion bit period.
// assumes: rc clock level arrives synchronous to ref_clk_in.
`default_nettype none

module sadc_bit_timer (
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rst_in,
    // control
    input  wire logic       run_in,
    input  wire logic [1:0] sel_in,
    input  wire logic       rc_clk_in,
    // period pulse
    output logic            tick_out
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    sadc_pkg::sadc_tmr_t st_r;                 // registered state
    sadc_pkg::sadc_tmr_t st_nxt;               // next state
    logic [4:0]          tc;                   // terminal count

    // divisor and tick
    always_comb begin
        st_nxt = st_r;
        st_nxt.rc_prev = rc_clk_in;
        tick_out = 1'b0;
        case (sel_in)
            sadc_pkg::SADC_CLK_DIV2:  tc = sadc_pkg::SADC_TC_DIV2;
            sadc_pkg::SADC_CLK_DIV8:  tc = sadc_pkg::SADC_TC_DIV8;
            default:                  tc = sadc_pkg::SADC_TC_DIV32;
        endcase
        if (!run_in) begin
            // counter held clear so every osc-divided run starts a whole period
            st_nxt.div = '0;
        end else if (sel_in == sadc_pkg::SADC_CLK_RC) begin
            // rc period: one tick per rising rc edge
            tick_out = rc_clk_in & ~st_r.rc_prev;
        end else if (st_r.div == tc) begin
            // osc divisor reached
            tick_out = 1'b1;
            st_nxt.div = '0;
        end else begin
            st_nxt.div = st_r.div + 5'h01;
        end
    end

    // state register
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= sadc_pkg::SADC_TMR_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule // sadc_bit_timer

`default_nettype wire

/* File: rtl/sadc_core.sv */
// sadc_core: register file and successive-approximation sequencer.
// assumes: comparator answer settles within one ref clock; register port
// strobes are single cycle and never overlap.
//
// The strobed register port was decided locally.
`default_nettype none

module sadc_core (
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rst_in,
    // register port
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // device state
    input  wire logic       sleep_in,
    input  wire logic       rc_clk_in,
    // converter core
    input  wire logic       comp_in,
    output logic      [7:0] dac_code_out,
    output logic      [2:0] channel_out,
    output logic            power_on_out,
    output logic            converting_out,
    output logic      [4:0] analog_pins_out,
    output logic            vref_ext_out,
    output logic            conv_irq_flag_out
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    sadc_pkg::sadc_regs_t st_r;                // all control state
    sadc_pkg::sadc_regs_t st_nxt;              // next control state
    logic [7:0]           result_r;            // conversion_result
    logic                 tick;                // bit period pulse
    logic                 wr_ctl;              // control zero write
    logic                 abort;               // run ends with no result
    logic                 done_evt;            // run completes this cycle
    logic [7:0]           kept;                // trial after comparison
    logic [7:0]           rd_mux;              // read data select

    // ------------------------------------------------------------------
    // bit period timer
    // ------------------------------------------------------------------
    sadc_bit_timer u_timer (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .run_in     (st_r.state == sadc_pkg::SADC_CONV),
        .sel_in     (st_r.conv_sel),
        .rc_clk_in  (rc_clk_in),
        .tick_out   (tick)
    );

    // ------------------------------------------------------------------
    // events
    // ------------------------------------------------------------------
    assign wr_ctl = wr_in && (addr_in == sadc_pkg::SADC_OFF_CTL0);

    // abort causes: start cleared, power dropped, sleep off the rc clock
    always_comb begin
        abort = 1'b0;
        if (st_r.state == sadc_pkg::SADC_CONV) begin
            if (wr_ctl && (!wdata_in[sadc_pkg::SADC_GO_BIT] || !wdata_in[sadc_pkg::SADC_POWER_BIT])) begin
                abort = 1'b1;
            end
            if (sleep_in && st_r.conv_sel != sadc_pkg::SADC_CLK_RC) begin
                abort = 1'b1;
            end
        end
    end

    assign done_evt = (st_r.state == sadc_pkg::SADC_CONV) && tick && !abort
                      && (st_r.step == sadc_pkg::SADC_LAST_STEP);

    // keep trial bit when sample is at or above the dac level
    assign kept = comp_in ? st_r.trial : (st_r.trial & ~st_r.mask);

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb begin
        case (addr_in)
            sadc_pkg::SADC_OFF_RESULT: rd_mux = result_r;
            sadc_pkg::SADC_OFF_CTL0:   rd_mux = {st_r.clk_sel, st_r.chan, st_r.go, 1'b0, st_r.power};
            sadc_pkg::SADC_OFF_PINCFG: rd_mux = {5'h00, st_r.pcfg};
            sadc_pkg::SADC_OFF_FLAG:   rd_mux = {7'h00, st_r.irq_flag};
            default:                   rd_mux = 8'h00;                  // unmapped
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (rd_in) begin
            st_nxt.rdata = rd_mux;
        end
        // software writes
        if (wr_ctl) begin
            st_nxt.clk_sel = wdata_in[7:6];
            st_nxt.chan    = wdata_in[5:3];
            st_nxt.power   = wdata_in[sadc_pkg::SADC_POWER_BIT];
            // start only takes while the written power bit is on
            st_nxt.go = wdata_in[sadc_pkg::SADC_GO_BIT] && wdata_in[sadc_pkg::SADC_POWER_BIT];
        end
        if (wr_in && addr_in == sadc_pkg::SADC_OFF_PINCFG) begin
            st_nxt.pcfg = wdata_in[2:0];
        end
        if (wr_in && addr_in == sadc_pkg::SADC_OFF_FLAG) begin
            st_nxt.irq_flag = wdata_in[sadc_pkg::SADC_FLAG_BIT];
        end
        // pin use decode, registered
        case (st_nxt.pcfg)
            3'h0, 3'h2: begin
                st_nxt.pin_mask = sadc_pkg::SADC_PINS_ALL;
                st_nxt.vref_ext = 1'b0;
            end
            3'h1, 3'h3: begin
                st_nxt.pin_mask = sadc_pkg::SADC_PINS_REF3;
                st_nxt.vref_ext = 1'b1;
            end
            3'h4: begin
                st_nxt.pin_mask = sadc_pkg::SADC_PINS_013;
                st_nxt.vref_ext = 1'b0;
            end
            3'h5: begin
                st_nxt.pin_mask = sadc_pkg::SADC_PINS_01;
                st_nxt.vref_ext = 1'b1;
            end
            default: begin
                st_nxt.pin_mask = sadc_pkg::SADC_PINS_NONE;
                st_nxt.vref_ext = 1'b0;
            end
        endcase
        // sequencer
        case (st_r.state)
            sadc_pkg::SADC_IDLE: begin
                if (st_nxt.go && st_nxt.power) begin
                    // begin run, clock choice held for its length
                    st_nxt.state    = sadc_pkg::SADC_CONV;
                    st_nxt.conv_sel = st_nxt.clk_sel;
                    st_nxt.step     = 4'h0;
                    st_nxt.trial    = sadc_pkg::SADC_MSB_MASK;
                    st_nxt.mask     = sadc_pkg::SADC_MSB_MASK;
                end
            end
            sadc_pkg::SADC_CONV: begin
                if (abort) begin
                    // partial code dropped; result untouched
                    st_nxt.state = sadc_pkg::SADC_IDLE;
                    st_nxt.go    = 1'b0;
                end else if (done_evt) begin
                    // completion clears start and sets flag
                    st_nxt.state    = sadc_pkg::SADC_IDLE;
                    st_nxt.go       = 1'b0;
                    st_nxt.irq_flag = 1'b1;    // set beats a same-cycle clear
                    st_nxt.trial    = kept;
                end else if (tick) begin
                    // step 0 is the hold period, steps 1..8 resolve bits
                    st_nxt.step = st_r.step + 4'h1;
                    if (st_r.step != 4'h0) begin
                        st_nxt.trial = kept | (st_r.mask >> 1);
                        st_nxt.mask  = st_r.mask >> 1;
                    end
                end
            end
            default: begin
                st_nxt.state = sadc_pkg::SADC_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // control state: everything back to reset values
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= sadc_pkg::SADC_REGS_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // result kept apart: deliberately no reset term
    always_ff @(posedge ref_clk_in) begin
        if (done_evt) begin
            result_r <= kept;
        end else if (wr_in && addr_in == sadc_pkg::SADC_OFF_RESULT) begin
            result_r <= wdata_in;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rdata_out         = st_r.rdata;
    assign dac_code_out      = st_r.trial;
    assign channel_out       = st_r.chan;
    assign power_on_out      = st_r.power;
    assign converting_out    = st_r.state == sadc_pkg::SADC_CONV;
    assign analog_pins_out   = st_r.pin_mask;
    assign vref_ext_out      = st_r.vref_ext;
    assign conv_irq_flag_out = st_r.irq_flag;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [8:0] conv_cyc;                      // cycles spent in a run
    logic [8:0] exp_cyc;                       // expected last cycle
    logic       wr_flag;                       // flag register written

    // software may set the flag itself beside an abort
    assign wr_flag = wr_in && (addr_in == sadc_pkg::SADC_OFF_FLAG);

    // run length counter for the timing check
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            conv_cyc <= 9'h000;
        end else if (st_r.state == sadc_pkg::SADC_CONV) begin
            conv_cyc <= conv_cyc + 9'h001;
        end else begin
            conv_cyc <= 9'h000;
        end
    end

    // nine periods of the held divisor, minus the starting cycle
    always_comb begin
        case (st_r.conv_sel)
            sadc_pkg::SADC_CLK_DIV2: exp_cyc = 9'h011;
            sadc_pkg::SADC_CLK_DIV8: exp_cyc = 9'h047;
            default:                 exp_cyc = 9'h11F;
        endcase
    end

    chk_done_event: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        done_evt |=> !st_r.go && st_r.irq_flag && result_r == $past(kept))
        else $error("completion did not load result, clear start and set flag");

    chk_run_length: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        done_evt && st_r.conv_sel != sadc_pkg::SADC_CLK_RC |-> conv_cyc == exp_cyc)
        else $error("conversion length is not nine bit periods");

    chk_off_idle: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !st_r.power |-> st_r.state == sadc_pkg::SADC_IDLE && !st_r.go)
        else $error("converter running while powered off");

    chk_abort_keeps: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        abort |=> $stable(result_r) && st_r.state == sadc_pkg::SADC_IDLE && !st_r.go
                  && (!$rose(st_r.irq_flag) || $past(wr_flag)))
        else $error("abort changed result, kept running or raised the flag");

    chk_sleep_abort: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        sleep_in && converting_out && st_r.conv_sel != sadc_pkg::SADC_CLK_RC |=> !converting_out ##1 !converting_out)
        else $error("conversion kept running in sleep without rc clock");

    chk_step_shift: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        converting_out && tick && !abort && !done_evt && st_r.step != 4'h0
        |=> st_r.mask == ($past(st_r.mask) >> 1) && st_r.step == $past(st_r.step) + 4'h1)
        else $error("approximation step did not advance by one bit");

    chk_pins_full: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        st_r.pcfg[2:1] != 2'h2 && !st_r.pcfg[2] |-> analog_pins_out[3] == !st_r.pcfg[0] && analog_pins_out[2])
        else $error("pin use wrong for full analog codes");

    chk_pins_digital: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        st_r.pcfg[2] |-> !analog_pins_out[2] && !analog_pins_out[4] && (st_r.pcfg[1] == (analog_pins_out == 5'h00)))
        else $error("pin use wrong for reduced analog codes");

    chk_cfg_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        rd_in && addr_in == sadc_pkg::SADC_OFF_PINCFG |=> rdata_out[7:3] == 5'h00)
        else $error("unimplemented pin config bits read non-zero");

    chk_reset_off: assert property (@(posedge ref_clk_in)
        $past(rst_in) && !rst_in |-> !power_on_out && !converting_out && analog_pins_out == 5'h1F)
        else $error("reset left converter on or pins not analog");

    cov_done: cover property (@(posedge ref_clk_in) disable iff (rst_in) done_evt);
    cov_abort: cover property (@(posedge ref_clk_in) disable iff (rst_in) abort);
    cov_rc_sleep: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        done_evt && sleep_in && st_r.conv_sel == sadc_pkg::SADC_CLK_RC);
    cov_go_off: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        wr_ctl && wdata_in[sadc_pkg::SADC_GO_BIT] && !wdata_in[sadc_pkg::SADC_POWER_BIT]);

endmodule // sadc_core

`default_nettype wire

/* File: test/sadc_analog_model.sv */
// sadc_analog_model: held channel samples and the comparator.
// assumes: samples stay still over a run; acquisition already done.
`default_nettype none

module sadc_analog_model (
    // converter core side
    input  wire logic [7:0] dac_code_in,
    input  wire logic [2:0] channel_in,
    input  wire logic       power_on_in,
    // comparator answer
    output logic            comp_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // held sample per channel, kept still through the hold
    logic [7:0] smp [5] = '{8'h5A, 8'hC3, 8'h01, 8'hFF, 8'h80};
    // powered off or bad channel: answer flips with the code, never a kind constant
    always_comb begin
        if (power_on_in && channel_in < 3'h5) begin
            comp_out = (smp[channel_in] >= dac_code_in);
        end else begin
            comp_out = ~dac_code_in[0];
        end
    end
endmodule // sadc_analog_model

`default_nettype wire

/* File: test/tb.sv */
// tb: register-port tests of the converter control block.
// assumes: sadc_core top, comparator model on its far side.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic       ref_clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic       sleep_in = 1'b0, rc_clk_in = 1'b0, comp_w;
    logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, dac_code_out, d;
    logic [2:0] channel_out;
    logic [4:0] analog_pins_out;
    logic       power_on_out, converting_out, vref_ext_out, conv_irq_flag_out;
    int         failures = 0, tests_run = 0, cyc = 0, n;
    logic [7:0] smp [5] = '{8'h5A, 8'hC3, 8'h01, 8'hFF, 8'h80};
    logic [4:0] pins [8] = '{5'h1F, 5'h17, 5'h1F, 5'h17, 5'h0B, 5'h03, 5'h00, 5'h00};

    sadc_core dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sleep_in(sleep_in), .rc_clk_in(rc_clk_in),
        .comp_in(comp_w), .dac_code_out(dac_code_out), .channel_out(channel_out),
        .power_on_out(power_on_out), .converting_out(converting_out), .analog_pins_out(analog_pins_out),
        .vref_ext_out(vref_ext_out), .conv_irq_flag_out(conv_irq_flag_out));
    sadc_analog_model model_u (.dac_code_in(dac_code_out), .channel_in(channel_out),
        .power_on_in(power_on_out), .comp_out(comp_w));

    // clock; rc clock free running at one fourteenth rate; hang guard
    initial forever #5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc % 7 == 6) rc_clk_in <= ~rc_clk_in;
        if (cyc == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    // read data taken just after the strobe edge; it holds until the next read
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rd(8'h1F);
        chk("ctl0", 16'(d), 16'h0000);
        chk("pins", 16'(analog_pins_out), 16'h001F);
        // every pin code, top bits written high must read zero
        for (int c = 0; c < 8; c++) begin
            wr(8'h9F, 8'hF8 | 8'(c));
            rd(8'h9F);
            chk("pincfg", 16'(d), 16'(c));
            chk("pins", 16'(analog_pins_out), 16'(pins[c]));
            chk("vref", 16'(vref_ext_out), 16'(c == 1 || c == 3 || c == 5));
        end
        wr(8'h1F, 8'h04);
        chk("offstart", 16'(converting_out), 16'h0000);
        chk("offflag", 16'(conv_irq_flag_out), 16'h0000);
        // one run per channel; clock codes 0,1,2,3(rc, asleep),0
        for (int i = 0; i < 5; i++) begin
            sleep_in <= (i == 3);
            wr(8'h1F, {i[1:0], i[2:0], 3'b001});
            repeat (70) @(posedge ref_clk_in); // over two slowest bit periods
            wr(8'h1F, {i[1:0], i[2:0], 3'b101});
            chk("chan", 16'(channel_out), 16'(i));
            n = 0;
            while (converting_out === 1'b1 && n < 2000) begin
                @(posedge ref_clk_in);
                #1;
                n++;
            end
            if (i != 3) chk("cycles", 16'(n), 16'(18 << (2 * i[1:0])));
            rd(8'h1E);
            chk("result", 16'(d), 16'(smp[i]));
            rd(8'h1F);
            chk("godone", 16'(d), 16'({i[1:0], i[2:0], 3'b001}));
            chk("flag", 16'(conv_irq_flag_out), 16'h0001);
            wr(8'h0C, 8'h00); // flag cleared before the next start
            chk("flagclr", 16'(conv_irq_flag_out), 16'h0000);
        end
        // software abort keeps the old result
        wr(8'h1F, 8'h85);
        repeat (100) @(posedge ref_clk_in); // two bits decided, partial code differs from old result
        wr(8'h1F, 8'h81);
        #10;
        chk("abort", 16'(converting_out), 16'h0000);
        rd(8'h1E);
        chk("kept", 16'(d), 16'(smp[4]));
        chk("noflag", 16'(conv_irq_flag_out), 16'h0000);
        // sleep on a divided clock stops the run, power bit kept
        sleep_in <= 1'b1;
        wr(8'h1F, 8'h05);
        #10;
        chk("sleepab", 16'(converting_out), 16'h0000);
        chk("sleeppw", 16'(power_on_out), 16'h0001);
        sleep_in <= 1'b0;
        // reset mid-run; result survives
        wr(8'h1E, 8'h3C);
        wr(8'h1F, 8'h45);
        rst_in <= 1'b1;
        #10;
        chk("rstconv", 16'(converting_out), 16'h0000);
        chk("rstpow", 16'(power_on_out), 16'h0000);
        rst_in <= 1'b0;
        rd(8'h1E);
        chk("rstres", 16'(d), 16'h003C);
        report_and_stop();
    end
endmodule // tb

`default_nettype wire
